// File: rtl/pfl_top.sv
/*
 * Quick link-drop and media pair-swap control with an APB register file.
 * Assumes trigger inputs come from logic on ref_clk and media pair inputs
 * come from pins; the link state machine outside acts on linkDrop.
 */
// Our own choices: the APB interface to the registers and the register offsets.
// Summary of operation
// - Polarity invert set inverts both the transmit and the receive pair.
// - Exchange clear: transmit and receive pairs keep their roles.
// - With pair exchange set, the pairs trade roles.
// - Mirroring is on only while polarity invert and exchange are both set.
// - Trigger bit 3: 32 MAC receive errors in a 10 us window drop the link.
// - Trigger bit 2: 20 code violations in a 10 us window drop the link.
// - Trigger bit 1: 20 low-SNR crossings in a 10 us window drop the link.
// - With trigger bit 0, a loss of signal energy drops the link at once.
// - The drop condition is the OR of all enabled triggers, in any mix.
// - Descrambler enable set: loss of descrambler lock drops the link.
module pfl_top
  import pfl_pkg::*;
#(
  parameter int WINDOW_CYCLES = WIN_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        linkUp,
  input  wire logic        rxErrEvt,
  input  wire logic        mlt3ViolEvt,
  input  wire logic        lowSnrEvt,
  input  wire logic        energyLoss,
  input  wire logic        descrLockLoss,
  input  wire pfl_diff_t   txSym,
  output pfl_diff_t        rxSym,
  input  wire pfl_diff_t   transmitPairIn,
  input  wire pfl_diff_t   receivePairIn,
  output pfl_diff_t        transmitPairOut,
  output logic             transmitPairOe,
  output pfl_diff_t        receivePairOut,
  output logic             receivePairOe,
  output logic             portMirror,
  output logic             linkDrop,
  output logic             irq
);

  if (WINDOW_CYCLES < 2) begin : g_chk
    $error("pfl_top: WINDOW_CYCLES must be at least 2");
  end

  // The cause vector fills every status bit below the drop bit.
  if (ST_DROP_POS != STAT_W - 1 ||
      ST_DESCR_POS != ST_DROP_POS - 1) begin : g_stat_chk
    $error("pfl_top: drop must be the top status bit");
  end

  localparam int TW = $clog2(WINDOW_CYCLES);
  localparam logic [TW-1:0] WIN_LAST = TW'(WINDOW_CYCLES - 1);

  function automatic pfl_diff_t flipPol(input pfl_diff_t d,
                                        input logic inv);
    flipPol = inv ? pfl_diff_t'{pos: d.neg, neg: d.pos} : d;
  endfunction : flipPol

  // Register file state.
  pfl_ctrl_t         ctrl_ff;
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] mask_ff;
  logic [15:0]       dropCnt_ff;

  // Bus decode. A transfer takes effect only in the cycle in which pready
  // is high, which is also the cycle in which the master samples it.
  logic apbAccess;
  logic apbDone;
  logic wrDone;
  logic rdDone;
  logic addrOk;
  logic [15:0] ctrlWord;

  assign apbAccess = psel & penable;
  assign apbDone   = apbAccess & pready;
  assign wrDone    = apbDone & pwrite;
  assign rdDone    = apbDone & ~pwrite;
  assign addrOk    = (paddr == CTRL_OFFS) || (paddr == STAT_OFFS) ||
                     (paddr == MASK_OFFS) || (paddr == DROP_OFFS);

  assign ctrlWord = {5'h00, ctrl_ff.descrDrop, 3'h0, ctrl_ff.polInv,
                     ctrl_ff.pairXchg, 1'b0, ctrl_ff.quickDrop};

  // Window timer shared by the counting triggers. It free-runs from reset
  // and is never realigned to link-up, so a burst that straddles a boundary
  // is split between two windows; that is the price of one shared timer.
  logic [TW-1:0] winCnt_ff;
  logic          winStart;

  assign winStart = (winCnt_ff == WIN_LAST);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      winCnt_ff <= '0;
    end else if (winStart) begin
      winCnt_ff <= '0;
    end else begin
      winCnt_ff <= winCnt_ff + TW'(1);
    end
  end

  // Counting triggers; a disabled trigger sees no events at all.
  logic rxErrFire;
  logic mlt3Fire;
  logic snrFire;

  pfl_win_counter #(
    .THRESH (RXERR_THRESH)
  ) u_rxerr_cnt (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .winStart (winStart),
    .evt      (rxErrEvt & ctrl_ff.quickDrop[QD_RXERR_POS]),
    .fire     (rxErrFire)
  );

  pfl_win_counter #(
    .THRESH (MLT3_THRESH)
  ) u_mlt3_cnt (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .winStart (winStart),
    .evt      (mlt3ViolEvt & ctrl_ff.quickDrop[QD_MLT3_POS]),
    .fire     (mlt3Fire)
  );

  pfl_win_counter #(
    .THRESH (SNR_THRESH)
  ) u_snr_cnt (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .winStart (winStart),
    .evt      (lowSnrEvt & ctrl_ff.quickDrop[QD_SNR_POS]),
    .fire     (snrFire)
  );

  // Trigger causes, one per status bit below the drop bit.
  // A disabled counting trigger never fires, its events being gated off.
  logic [ST_DROP_POS-1:0] cause;
  logic                   anyCause;

  always_comb begin
    cause                = '0;
    cause[QD_ENERGY_POS] = energyLoss &
                           ctrl_ff.quickDrop[QD_ENERGY_POS];
    cause[QD_SNR_POS]    = snrFire;
    cause[QD_MLT3_POS]   = mlt3Fire;
    cause[QD_RXERR_POS]  = rxErrFire;
    cause[ST_DESCR_POS]  = descrLockLoss & ctrl_ff.descrDrop;
  end

  assign anyCause = |cause;

  // Drop is only meaningful on a live link; a level cause such as energy
  // loss holds linkDrop high until the link state machine takes linkUp down.
  logic dropEvt;

  assign dropEvt = linkUp & anyCause;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      linkDrop <= 1'b0;
    end else begin
      linkDrop <= dropEvt;
    end
  end

  // Saturates instead of wrapping, so software never reads a small count
  // after a storm of drops.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dropCnt_ff <= '0;
    end else if (dropEvt && dropCnt_ff != 16'hFFFF) begin
      dropCnt_ff <= dropCnt_ff + 16'h0001;
    end
  end

  // Control register; reserved bits ignore writes.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= '{descrDrop: CTRL_RESET[QD_DESCR_POS],
                   polInv:    CTRL_RESET[POL_INV_POS],
                   pairXchg:  CTRL_RESET[PAIR_XCHG_POS],
                   quickDrop: CTRL_RESET[3:0]};
    end else if (wrDone && paddr == CTRL_OFFS) begin
      ctrl_ff.descrDrop <= pwdata[QD_DESCR_POS];
      ctrl_ff.polInv    <= pwdata[POL_INV_POS];
      ctrl_ff.pairXchg  <= pwdata[PAIR_XCHG_POS];
      ctrl_ff.quickDrop <= pwdata[3:0];
    end
  end

  // Mask bits line up with status bits; the interrupt is their AND.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff <= MASK_RESET;
    end else if (wrDone && paddr == MASK_OFFS) begin
      mask_ff <= pwdata[STAT_W-1:0];
    end
  end

  // Sticky status: a read clears only the bits that it returned, so a cause
  // that lands between the capture of the read word and the end of the
  // transfer survives to the next read. A cause in the clearing cycle wins.
  logic [STAT_W-1:0] statSet;
  logic              statRdClr;
  logic [STAT_W-1:0] statClr;
  logic [STAT_W-1:0] nxt_stat;

  assign statSet   = dropEvt ? {1'b1, cause} : '0;
  assign statRdClr = rdDone && (paddr == STAT_OFFS);
  assign statClr   = statRdClr ? prdata[STAT_W-1:0] : '0;
  assign nxt_stat  = (stat_ff & ~statClr) | statSet;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff <= STAT_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // The interrupt follows the next status value, so it falls together with
  // the status bits that a clearing read removes.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_stat & mask_ff);
    end
  end

  // APB slave: one wait state, so pready rises in the second access cycle.
  // An unmapped address answers with an error in that same cycle; a write
  // to it changes nothing and a read returns zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess & ~pready;
      pslverr <= apbAccess & ~pready & ~addrOk;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (apbAccess && !pready && !pwrite) begin
      unique case (paddr)
        CTRL_OFFS: prdata <= {16'h0000, ctrlWord};
        STAT_OFFS: prdata <= {26'h000_0000, stat_ff};
        MASK_OFFS: prdata <= {26'h000_0000, mask_ff};
        DROP_OFFS: prdata <= {16'h0000, dropCnt_ff};
        default:   prdata <= 32'h0000_0000;
      endcase
    end else begin
      // Zero outside the answer cycle, so no stale word lingers on the bus.
      prdata <= 32'h0000_0000;
    end
  end

  // Media pair steering. Pins are synchronised before use; the outgoing
  // symbol is registered so every pin output comes from a flip-flop.
  pfl_diff_t txPinSync;
  pfl_diff_t rxPinSync;

  pfl_sync #(
    .WIDTH (2)
  ) u_tx_pin_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (transmitPairIn),
    .dout    (txPinSync)
  );

  pfl_sync #(
    .WIDTH (2)
  ) u_rx_pin_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (receivePairIn),
    .dout    (rxPinSync)
  );

  // Polarity flips the symbol itself, so it acts alike on whichever pair
  // carries it.
  pfl_diff_t txLine;
  pfl_diff_t rxLine;

  assign txLine = flipPol(txSym, ctrl_ff.polInv);
  assign rxLine = flipPol(ctrl_ff.pairXchg ? txPinSync : rxPinSync,
                          ctrl_ff.polInv);

  // The pair that is not driven is held low with its enable off; the cable
  // partner owns it then.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      transmitPairOut <= '0;
      transmitPairOe  <= 1'b0;
      receivePairOut  <= '0;
      receivePairOe   <= 1'b0;
    end else if (ctrl_ff.pairXchg) begin
      transmitPairOut <= '0;
      transmitPairOe  <= 1'b0;
      receivePairOut  <= txLine;
      receivePairOe   <= 1'b1;
    end else begin
      transmitPairOut <= txLine;
      transmitPairOe  <= 1'b1;
      receivePairOut  <= '0;
      receivePairOe   <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxSym <= '0;
    end else begin
      rxSym <= rxLine;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portMirror <= 1'b0;
    end else begin
      portMirror <= ctrl_ff.polInv & ctrl_ff.pairXchg;
    end
  end

endmodule : pfl_top

// File: rtl/pfl_pkg.sv
/*
 * Shared constants and types of the quick link-drop and pair-swap block.
 * Assumes a 200 MHz core clock; the window cycle count WIN_CYC derives from that rate.
 */
package pfl_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STAT_OFFS = 8'h04;
  localparam logic [7:0] MASK_OFFS = 8'h08;
  localparam logic [7:0] DROP_OFFS = 8'h0C;

  // Field positions of the control register.
  localparam int QD_ENERGY_POS = 0;
  localparam int QD_SNR_POS    = 1;
  localparam int QD_MLT3_POS   = 2;
  localparam int QD_RXERR_POS  = 3;
  localparam int PAIR_XCHG_POS = 5;
  localparam int POL_INV_POS   = 6;
  localparam int QD_DESCR_POS  = 10;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h0460;
  localparam logic [15:0] CTRL_QMASK = 16'h000F;

  // Status and mask layout: one bit per trigger cause plus the drop event.
  localparam int STAT_W        = 6;
  localparam int ST_DROP_POS   = 5;
  localparam int ST_DESCR_POS  = 4;
  localparam logic [STAT_W-1:0] STAT_RESET = 6'h00;
  localparam logic [STAT_W-1:0] MASK_RESET = 6'h00;

  // Observation window and trigger thresholds.
  localparam int CLK_MHZ      = 200;
  localparam int WIN_NS       = 10000;
  localparam int WIN_CYC      = (WIN_NS * CLK_MHZ) / 1000;
  localparam int RXERR_THRESH = 32;
  localparam int MLT3_THRESH  = 20;
  localparam int SNR_THRESH   = 20;

  // One differential pair as two single-ended legs.
  typedef struct packed {
    logic pos;
    logic neg;
  } pfl_diff_t;

  typedef struct packed {
    logic       descrDrop;
    logic       polInv;
    logic       pairXchg;
    logic [3:0] quickDrop;
  } pfl_ctrl_t;

endpackage : pfl_pkg

// File: rtl/pfl_sync.sv
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes the input is asynchronous to ref_clk.
 */
module pfl_sync
  import pfl_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // Only the second stage reads the first; the output moves per bit once
  // the second and third stages agree, so a one-cycle glitch is dropped.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
      dout    <= (s2_ff & s3_ff) | (dout & (s2_ff | s3_ff));
    end
  end

endmodule : pfl_sync

// File: rtl/pfl_win_counter.sv
/*
 * Event counter that fires once per window on reaching its threshold.
 * Assumes winStart pulses for one cycle at the start of each window.
 */
module pfl_win_counter
  import pfl_pkg::*;
#(
  parameter int THRESH = 20,
  parameter int CW     = $clog2(THRESH + 1)
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic winStart,
  input  wire logic evt,
  output logic      fire
);

  if (THRESH < 1) begin : g_chk
    $error("pfl_win_counter: THRESH must be at least 1");
  end

  localparam logic [CW-1:0] LIMIT = CW'(THRESH);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  // An event in the window's first cycle counts toward the new window.
  always_comb begin
    nxt_cnt = winStart ? '0 : cnt_ff;
    if (evt && nxt_cnt != LIMIT)
      nxt_cnt = nxt_cnt + CW'(1);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      fire   <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fire   <= (nxt_cnt == LIMIT) && (cnt_ff != LIMIT || winStart);
    end
  end

endmodule : pfl_win_counter

// File: sim/pfl_top_assertions.sv
/*
 * Concurrent checks on the ports of pfl_top, bound into every instance.
 * Assumes pfl_pkg is compiled first and one clock domain on ref_clk.
 */
module pfl_chk
  import pfl_pkg::*;
(
  input logic        ref_clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  input logic        linkUp,
  input logic        rxErrEvt,
  input logic        mlt3ViolEvt,
  input logic        lowSnrEvt,
  input logic        energyLoss,
  input logic        descrLockLoss,
  input pfl_diff_t   txSym,
  input pfl_diff_t   receivePairOut,
  input logic        transmitPairOe,
  input logic        receivePairOe,
  input logic        portMirror,
  input logic        linkDrop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_apb;
    psel && !penable ##1 psel && penable;
  endsequence

  a_one_wait: assert property (s_apb |=> pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  a_oe_oneside: assert property (
    $past(nrst) |-> transmitPairOe != receivePairOe)
    else $error("both or no pair driven");
  a_mirror_oe: assert property (
    portMirror |-> receivePairOe && !transmitPairOe)
    else $error("mirror without pair exchange");
  a_mirror_path: assert property (
    portMirror && $past(portMirror) |->
      receivePairOut == {$past(txSym.neg), $past(txSym.pos)})
    else $error("mirrored transmit path wrong");
  a_drop_link: assert property (linkDrop |-> $past(linkUp))
    else $error("drop while link down");
  a_drop_cause: assert property (
    linkDrop |-> $past(energyLoss || descrLockLoss) ||
      $past(rxErrEvt || mlt3ViolEvt || lowSnrEvt, 2))
    else $error("drop without cause");
endmodule : pfl_chk

bind pfl_top pfl_chk u_pfl_chk (.ref_clk, .nrst, .psel, .penable, .pready,
  .pslverr, .prdata, .linkUp, .rxErrEvt, .mlt3ViolEvt, .lowSnrEvt,
  .energyLoss, .descrLockLoss, .txSym, .receivePairOut, .transmitPairOe,
  .receivePairOe, .portMirror, .linkDrop);

// File: sim/pfl_partner.sv
/*
 * Link partner at the far end of the cable, sending its own symbol.
 * Assumes the device drives exactly one pair at a time.
 */
module pfl_partner
  import pfl_pkg::*;
(
  input  pfl_diff_t farSym,
  input  pfl_diff_t txOut,
  input  logic      txOe,
  input  pfl_diff_t rxOut,
  input  logic      rxOe,
  output pfl_diff_t txWire,
  output pfl_diff_t rxWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // The partner drives whichever pair the device leaves free.
  assign txWire = txOe ? txOut : farSym;
  assign rxWire = rxOe ? rxOut : farSym;
endmodule : pfl_partner

// File: sim/tb.sv
/*
 * Self-checking bench for pfl_top with a cable partner and bound checker.
 * Assumes a shortened window; the bench phase counter tracks it.
 */
module tb import pfl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 200;
  localparam int LIMIT = 20000;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        linkUp, tpOe, rpOe, portMirror, linkDrop, irq;
  logic [4:0]  trig;
  logic [1:0]  c;
  logic [33:0] e;
  logic [33:0] q[$];
  pfl_diff_t   txSym, rxSym, farSym, tpIn, rpIn, tpOut, rpOut, p;
  int          seed, errTotal, numChecks, drops, cyc, ph, d0, n;

  pfl_top #(.WINDOW_CYCLES(W)) u_pfl_top (.ref_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .linkUp,
    .rxErrEvt(trig[3]), .mlt3ViolEvt(trig[2]), .lowSnrEvt(trig[1]),
    .energyLoss(trig[0]), .descrLockLoss(trig[4]), .txSym, .rxSym,
    .transmitPairIn(tpIn), .receivePairIn(rpIn), .transmitPairOut(tpOut),
    .transmitPairOe(tpOe), .receivePairOut(rpOut), .receivePairOe(rpOe),
    .portMirror, .linkDrop, .irq);
  pfl_partner u_pfl_partner (.farSym, .txOut(tpOut), .txOe(tpOe),
    .rxOut(rpOut), .rxOe(rpOe), .txWire(tpIn), .rxWire(rpIn));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task results;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic er);
    @(posedge ref_clk);
    q.push_back({!wr, er, x});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic burst(input int k, input int len);
    trig[k] <= 1'b1;
    repeat (len) @(posedge ref_clk);
    trig <= 5'h00;
  endtask : burst

  // Events start well inside a window so reset skew cannot split them.
  task automatic waitPh;
    do @(posedge ref_clk); while (ph != 20);
  endtask : waitPh

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    ph <= (!nrst || ph == W - 1) ? 0 : ph + 1;
    if (linkDrop === 1'b1) drops++;
    if (pready === 1'b1 && psel === 1'b1) begin
      e = q.pop_front();
      chk(32'(pslverr), 32'(e[32]));
      if (e[33]) chk(prdata, e[31:0]);
    end
    if (cyc == LIMIT) begin
      errTotal++;
      results();
    end
  end

  initial begin
    {nrst, psel, penable, pwrite, linkUp, paddr, pwdata} = '0;
    {trig, txSym, farSym, cyc, ph, drops, errTotal, numChecks} = '0;
    seed = 16;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    linkUp <= 1'b1;
    for (int a = 0; a < 5; a++) apb(0, 8'(a * 4), 0, 0, a == 4);
    apb(1, 8'h10, 32'hFFFF_FFFF, 0, 1);
    apb(1, CTRL_OFFS, 32'hFFFF_FFFF, 0, 0);
    apb(0, CTRL_OFFS, 0, 32'h0000_046F, 0);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      apb(1, CTRL_OFFS, {25'h0, c, 5'h00}, 0, 0);
      txSym <= 2'($random(seed));
      farSym <= 2'($random(seed));
      // The freed pair reaches rxSym through the pin synchroniser five
      // cycles after its enable drops, so wait past that.
      repeat (8) @(posedge ref_clk);
      p = c[1] ? {txSym.neg, txSym.pos} : txSym;
      chk(32'({tpOut, tpOe, rpOut, rpOe, portMirror}),
          32'({c[0] ? 2'b00 : p, !c[0], c[0] ? p : 2'b00, c[0], &c}));
      chk(32'(rxSym),
          32'(c[1] ? {farSym.neg, farSym.pos} : farSym));
    end
    apb(1, MASK_OFFS, 32'h0000_003F, 0, 0);
    for (int k = 0; k < 5; k += 4) begin
      apb(1, CTRL_OFFS, k ? 32'h0000_0400 : 32'h0000_0001, 0, 0);
      d0 = drops;
      burst(k, 1);
      repeat (3) @(posedge ref_clk);
      chk(32'(drops - d0), 1);
      chk(32'(irq), 1);
      apb(0, STAT_OFFS, 0, 32'(6'h20 | (6'h01 << k)), 0);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 0);
    end
    linkUp <= 1'b0;
    d0 = drops;
    burst(4, 1);
    repeat (3) @(posedge ref_clk);
    chk(32'(drops - d0), 0);
    apb(0, STAT_OFFS, 0, 0, 0);
    linkUp <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      n = (k == 3) ? RXERR_THRESH : (k == 2) ? MLT3_THRESH : SNR_THRESH;
      apb(1, CTRL_OFFS, 32'(1 << k), 0, 0);
      d0 = drops;
      waitPh();
      burst(k, n - 1);
      waitPh();
      burst(k, 1);
      repeat (4) @(posedge ref_clk);
      chk(32'(drops - d0), 0);
      waitPh();
      burst(k, n);
      repeat (4) @(posedge ref_clk);
      chk(32'(drops - d0), 1);
      apb(0, STAT_OFFS, 0, 32'(6'h20 | (6'h01 << k)), 0);
    end
    apb(1, CTRL_OFFS, 0, 0, 0);
    d0 = drops;
    waitPh();
    burst(1, SNR_THRESH);
    repeat (4) @(posedge ref_clk);
    chk(32'(drops - d0), 0);
    apb(1, CTRL_OFFS, 32'h0000_040F, 0, 0);
    burst(0, 1);
    repeat (3) @(posedge ref_clk);
    chk(32'(drops - d0), 1);
    apb(0, DROP_OFFS, 0, 32'h0000_0006, 0);
    // Let the monitor compare the last answer before the run ends.
    repeat (2) @(posedge ref_clk);
    results();
  end
endmodule : tb
